// ---- hw/sse_pkg.sv ----
// constants and carriers for the subtract/swap/exchange execution unit
// assumes one core clock and a decode stage that presents whole instructions
package sse_pkg;

	// ----------------------------------------
	// opcodes and opcode masks
	// ----------------------------------------
	localparam logic [7:0] SUB_REG_PAT = 8'h98;
	localparam logic [7:0] REG_MASK = 8'hf8;
	localparam logic [7:0] SUB_DIR_OP = 8'h95;
	localparam logic [7:0] SUB_IND_PAT = 8'h96;
	localparam logic [7:0] IND_MASK = 8'hfe;
	localparam logic [7:0] SUB_IMM_OP = 8'h94;
	localparam logic [7:0] SWAP_OP = 8'hc4;
	localparam logic [7:0] XCH_REG_PAT = 8'hc8;
	localparam logic [7:0] XCH_DIR_OP = 8'hc5;
	localparam logic [7:0] XCH_IND_PAT = 8'hc6;

	// ----------------------------------------
	// field positions and sizes
	// ----------------------------------------
	localparam int RAM_DEPTH = 256;
	localparam int CARRY_BIT = 8;
	localparam int AUX_BIT = 4;
	localparam int SIGN_IN_BIT = 7;

	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic FLAG_RESET = 1'b0;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_SUB = 2'b01,
		OP_SWAP = 2'b10,
		OP_XCH = 2'b11
	} sse_op_e;

	typedef enum logic [1:0] {
		SRC_REG = 2'b00,
		SRC_DIR = 2'b01,
		SRC_IND = 2'b10,
		SRC_IMM = 2'b11
	} sse_src_e;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] operand;
	} sse_instr_s;

	typedef struct packed {
		logic cy;
		logic ac;
		logic ov;
	} sse_flags_s;

endpackage

// ---- hw/sse_exec.sv ----
// execution unit for subtract with borrow, nibble swap and accumulator exchange
// assumes the decode stage presents one whole instruction per valid cycle
//
// Contract
// - subtract source operand and carry from accumulator, result back into accumulator
// - carry set on borrow out of bit 7, cleared otherwise
// - auxiliary carry set on borrow from bit 3, cleared otherwise
// - overflow is exclusive-or of borrows into bit 7 and out of bit 7
// - subtract source may be bank register, direct, indirect or immediate
// - opcode 1001 1rrr subtracts a bank register, one byte, one cycle
// - opcode 1001 0101 plus direct address subtracts direct byte, one cycle
// - immediate form subtracts carry and the instruction's data byte
// - nibble swap exchanges accumulator halves, flags untouched
// - opcode 1100 0100 is nibble swap, one byte, one cycle
// - exchange loads accumulator from byte and writes old accumulator there together
// - exchange operand may be bank register, direct or indirect
// - direct exchange is opcode plus address byte, executes in one cycle
`timescale 1ns/1ps
module sse_exec (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// instruction from decode
	input wire logic instrValid,
	input wire sse_pkg::sse_instr_s instr,
	input wire logic [1:0] bankSel,
	// ram preload and inspection
	input wire logic hostWrEn,
	input wire logic [7:0] hostAddr,
	input wire logic [7:0] hostWrData,
	output logic [7:0] hostRdData,
	// accumulator and carry preload
	input wire logic accLoad,
	input wire logic [7:0] accLoadData,
	input wire logic carryLoad,
	input wire logic carryLoadData,
	// architectural state and status
	output logic [7:0] acc,
	output sse_pkg::sse_flags_s flags,
	output logic done,
	output logic illegal
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] ram [0:sse_pkg::RAM_DEPTH-1];
	logic [7:0] accQ, accD;
	sse_pkg::sse_flags_s flagsQ, flagsD;
	logic doneQ, doneD;
	logic illegalQ, illegalD;
	logic [7:0] hostRdQ, hostRdD;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	sse_pkg::sse_op_e op;
	sse_pkg::sse_src_e src;
	logic known;

	always_comb begin
		op = sse_pkg::OP_NONE;
		src = sse_pkg::SRC_REG;
		known = 1'b1;
		if ((instr.opcode & sse_pkg::REG_MASK) == sse_pkg::SUB_REG_PAT) begin
			op = sse_pkg::OP_SUB;
			src = sse_pkg::SRC_REG;
		end else if (instr.opcode == sse_pkg::SUB_DIR_OP) begin
			op = sse_pkg::OP_SUB;
			src = sse_pkg::SRC_DIR;
		end else if ((instr.opcode & sse_pkg::IND_MASK) == sse_pkg::SUB_IND_PAT) begin
			op = sse_pkg::OP_SUB;
			src = sse_pkg::SRC_IND;
		end else if (instr.opcode == sse_pkg::SUB_IMM_OP) begin
			op = sse_pkg::OP_SUB;
			src = sse_pkg::SRC_IMM;
		end else if (instr.opcode == sse_pkg::SWAP_OP) begin
			op = sse_pkg::OP_SWAP;
		end else if ((instr.opcode & sse_pkg::REG_MASK) == sse_pkg::XCH_REG_PAT) begin
			op = sse_pkg::OP_XCH;
			src = sse_pkg::SRC_REG;
		end else if (instr.opcode == sse_pkg::XCH_DIR_OP) begin
			op = sse_pkg::OP_XCH;
			src = sse_pkg::SRC_DIR;
		end else if ((instr.opcode & sse_pkg::IND_MASK) == sse_pkg::XCH_IND_PAT) begin
			op = sse_pkg::OP_XCH;
			src = sse_pkg::SRC_IND;
		end else begin
			known = 1'b0;
		end
	end

	// ----------------------------------------
	// operand fetch
	// ----------------------------------------
	// register banks sit at the bottom of ram, eight bytes per bank
	logic [7:0] regAddr, ptrAddr, operAddr, srcByte;

	assign regAddr = {3'b000, bankSel, instr.opcode[2:0]};
	assign ptrAddr = {3'b000, bankSel, 2'b00, instr.opcode[0]};

	always_comb begin
		case (src)
			sse_pkg::SRC_REG: operAddr = regAddr;
			sse_pkg::SRC_DIR: operAddr = instr.operand;
			sse_pkg::SRC_IND: operAddr = ram[ptrAddr];
			default: operAddr = 8'h00;
		endcase
		srcByte = (src == sse_pkg::SRC_IMM) ? instr.operand : ram[operAddr];
	end

	// ----------------------------------------
	// arithmetic
	// ----------------------------------------
	// three narrow subtractions expose borrows at bits 3, 6 and 7 directly
	logic [8:0] diff9;
	logic [4:0] diff4;
	logic [7:0] diff7;

	always_comb begin
		diff9 = {1'b0, accQ} - {1'b0, srcByte} - {8'h00, flagsQ.cy};
		diff4 = {1'b0, accQ[3:0]} - {1'b0, srcByte[3:0]} - {4'h0, flagsQ.cy};
		diff7 = {1'b0, accQ[6:0]} - {1'b0, srcByte[6:0]} - {7'h00, flagsQ.cy};
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic memWe;
	logic [7:0] memAddr, memData;

	always_comb begin
		accD = accQ;
		flagsD = flagsQ;
		doneD = 1'b0;
		illegalD = 1'b0;
		memWe = 1'b0;
		memAddr = hostAddr;
		memData = hostWrData;
		hostRdD = ram[hostAddr];
		if (instrValid) begin
			doneD = known;
			illegalD = ~known;
			case (op)
				sse_pkg::OP_SUB: begin
					accD = diff9[7:0];
					flagsD.cy = diff9[sse_pkg::CARRY_BIT];
					flagsD.ac = diff4[sse_pkg::AUX_BIT];
					flagsD.ov = diff7[sse_pkg::SIGN_IN_BIT] ^ diff9[sse_pkg::CARRY_BIT];
				end
				sse_pkg::OP_SWAP: begin
					accD = {accQ[3:0], accQ[7:4]};
				end
				sse_pkg::OP_XCH: begin
					accD = srcByte;
					memWe = 1'b1;
					memAddr = operAddr;
					memData = accQ;
				end
				default: begin
					accD = accQ;
				end
			endcase
		end else begin
			// preloads only act between instructions, execution always wins
			memWe = hostWrEn;
			if (accLoad) begin
				accD = accLoadData;
			end
			if (carryLoad) begin
				flagsD.cy = carryLoadData;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			accQ <= sse_pkg::ACC_RESET;
			flagsQ <= '{cy: sse_pkg::FLAG_RESET, ac: sse_pkg::FLAG_RESET, ov: sse_pkg::FLAG_RESET};
			doneQ <= 1'b0;
			illegalQ <= 1'b0;
			hostRdQ <= 8'h00;
		end else begin
			accQ <= accD;
			flagsQ <= flagsD;
			doneQ <= doneD;
			illegalQ <= illegalD;
			hostRdQ <= hostRdD;
		end
	end

	// ram holds no reset; contents are defined only once written
	always_ff @(posedge clk) begin
		if (memWe) begin
			ram[memAddr] <= memData;
		end
	end

	assign acc = accQ;
	assign flags = flagsQ;
	assign done = doneQ;
	assign illegal = illegalQ;
	assign hostRdData = hostRdQ;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	logic isSub, isSwap, isXch;
	assign isSub = instrValid && op == sse_pkg::OP_SUB;
	assign isSwap = instrValid && op == sse_pkg::OP_SWAP;
	assign isXch = instrValid && op == sse_pkg::OP_XCH;

	sequence subIssued;
		isSub;
	endsequence

	sequence doneNext;
		done && !illegal;
	endsequence

	chk_sub_result: assert property (subIssued |=>
		acc == 8'($past(accQ) - $past(srcByte) - {7'h00, $past(flagsQ.cy)}))
		else $error("subtract result wrong");
	chk_sub_carry: assert property (subIssued |=>
		flags.cy == ({1'b0, $past(accQ)} < {1'b0, $past(srcByte)} + {8'h00, $past(flagsQ.cy)}))
		else $error("carry after subtract wrong");
	chk_sub_aux: assert property (subIssued |=>
		flags.ac == ({1'b0, $past(accQ[3:0])} < {1'b0, $past(srcByte[3:0])} + {4'h0, $past(flagsQ.cy)}))
		else $error("aux carry after subtract wrong");
	chk_sub_overflow: assert property (subIssued |=>
		flags.ov == (($past(accQ[7]) != $past(srcByte[7])) && (acc[7] != $past(accQ[7]))))
		else $error("overflow after subtract wrong");
	// result judged against the instruction byte itself, not the internal mux
	chk_imm_source: assert property ((isSub && src == sse_pkg::SRC_IMM) |=>
		acc == 8'($past(accQ) - $past(instr.operand) - {7'h00, $past(flagsQ.cy)}))
		else $error("immediate operand not used");
	chk_reg_decode: assert property ((instrValid && (instr.opcode & sse_pkg::REG_MASK) == sse_pkg::SUB_REG_PAT) |->
		isSub && operAddr == {3'b000, bankSel, instr.opcode[2:0]})
		else $error("bank register subtract decode wrong");
	chk_bank_select: assert property ((isXch && src == sse_pkg::SRC_REG) |->
		operAddr[7:3] == {3'b000, bankSel})
		else $error("bank register address wrong");
	chk_dir_single: assert property ((instrValid && instr.opcode == sse_pkg::SUB_DIR_OP) |->
		(isSub && operAddr == instr.operand) ##1 doneNext)
		else $error("direct subtract not single cycle");
	chk_swap_halves: assert property (isSwap |=>
		acc == {$past(accQ[3:0]), $past(accQ[7:4])} && $stable(flags) && done)
		else $error("swap result or flags wrong");
	chk_xch_both: assert property (isXch |->
		(memWe && memAddr == operAddr && memData == accQ) ##1 (acc == $past(srcByte)))
		else $error("exchange not done both ways");
	chk_xch_flags: assert property (isXch && src == sse_pkg::SRC_DIR |=> $stable(flags) && done)
		else $error("direct exchange not single cycle");

endmodule

// ---- test/sse_decode_model.sv ----
// decode-side stand-in that presents one whole instruction per call
// assumes the bench calls send from one process at a time
`timescale 1ns/1ps
module sse_decode_model (
	// clock
	input wire logic clk,
	// instruction to the unit
	output logic instrValid,
	output sse_pkg::sse_instr_s instr
);
	initial begin
		instrValid = 1'b0;
		instr = 16'h0000;
	end
	// second byte rides in the same cycle
	task automatic send(input logic [7:0] op, input logic [7:0] opd);
		@(negedge clk);
		instrValid = 1'b1;
		instr = {op, opd};
		@(negedge clk);
		instrValid = 1'b0;
		// idle lines must not keep the last value
		instr = ~instr;
	endtask
endmodule

// ---- test/tb.sv ----
// self-checking bench for the subtract/swap/exchange unit
// assumes the decode model drives instructions, bench drives preloads
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic instrValid;
	sse_pkg::sse_instr_s instr;
	logic [1:0] bankSel = 2'h0;
	logic hostWrEn = 1'b0;
	logic [7:0] hostAddr = 8'h00;
	logic [7:0] hostWrData = 8'h00;
	logic [7:0] hostRdData;
	logic accLoad = 1'b0;
	logic [7:0] accLoadData = 8'h00;
	logic carryLoad = 1'b0;
	logic carryLoadData = 1'b0;
	logic [7:0] acc;
	sse_pkg::sse_flags_s flags;
	logic done;
	logic illegal;
	int mismatches = 0;
	int compares = 0;
	always #2.5 clk = ~clk;
	sse_decode_model u_sse_decode_model (.clk(clk), .instrValid(instrValid), .instr(instr));
	sse_exec u_sse_exec (.clk(clk), .rstn(rstn), .instrValid(instrValid), .instr(instr), .bankSel(bankSel),
		.hostWrEn(hostWrEn), .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData),
		.accLoad(accLoad), .accLoadData(accLoadData), .carryLoad(carryLoad), .carryLoadData(carryLoadData),
		.acc(acc), .flags(flags), .done(done), .illegal(illegal));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("mismatches=%0d compares=%0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic poke(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		hostWrEn = 1'b1;
		hostAddr = a;
		hostWrData = d;
		@(negedge clk);
		hostWrEn = 1'b0;
		hostWrData = ~d;
	endtask
	task automatic peek(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		hostAddr = a;
		@(negedge clk);
		cmp(hostRdData, exp);
	endtask
	task automatic setA(input logic [7:0] a, input logic c);
		@(negedge clk);
		accLoad = 1'b1;
		accLoadData = a;
		carryLoad = 1'b1;
		carryLoadData = c;
		@(negedge clk);
		accLoad = 1'b0;
		carryLoad = 1'b0;
	endtask
	// done/illegal looked at in the single cycle they stand
	task automatic exec(input logic [7:0] op, opd, expA, input logic [2:0] expF, input logic ill);
		u_sse_decode_model.send(op, opd);
		cmp({6'h00, done, illegal}, ill ? 8'h01 : 8'h02);
		cmp(acc, expA);
		cmp({5'h00, flags}, {5'h00, expF});
		// status pulses must fall after one cycle
		@(negedge clk);
		cmp({6'h00, done, illegal}, 8'h00);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_sub_reg();
		bankSel = 2'h1;
		poke(8'h02, 8'h00);
		poke(8'h0a, 8'h54);
		setA(8'hc9, 1'b1);
		exec(8'h9a, 8'h00, 8'h74, 3'b001, 1'b0);
	endtask
	task automatic t_sub_dir_ind();
		bankSel = 2'h0;
		poke(8'h30, 8'h01);
		setA(8'h00, 1'b0);
		exec(8'h95, 8'h30, 8'hff, 3'b110, 1'b0);
		poke(8'h00, 8'h40);
		poke(8'h40, 8'h10);
		setA(8'h10, 1'b1);
		exec(8'h96, 8'h00, 8'hff, 3'b110, 1'b0);
	endtask
	task automatic t_imm_swap();
		setA(8'h80, 1'b0);
		exec(8'h94, 8'h01, 8'h7f, 3'b011, 1'b0);
		setA(8'hc5, 1'b0);
		exec(8'hc4, 8'h00, 8'h5c, 3'b011, 1'b0);
	endtask
	task automatic t_xch();
		bankSel = 2'h2;
		poke(8'h13, 8'h11);
		poke(8'h20, 8'h22);
		poke(8'h11, 8'h40);
		poke(8'h40, 8'h44);
		setA(8'h3f, 1'b1);
		exec(8'hcb, 8'h00, 8'h11, 3'b111, 1'b0);
		peek(8'h13, 8'h3f);
		exec(8'hc5, 8'h20, 8'h22, 3'b111, 1'b0);
		peek(8'h20, 8'h11);
		exec(8'hc7, 8'h00, 8'h44, 3'b111, 1'b0);
		peek(8'h40, 8'h22);
		exec(8'ha5, 8'h00, 8'h44, 3'b111, 1'b1);
	endtask
	// preloads presented alongside an instruction must be dropped
	task automatic t_refused();
		setA(8'h30, 1'b0);
		fork
			exec(8'h97, 8'h00, 8'h0e, 3'b010, 1'b0);
			begin
				@(negedge clk);
				accLoad = 1'b1;
				accLoadData = 8'haa;
				carryLoad = 1'b1;
				carryLoadData = 1'b1;
				hostWrEn = 1'b1;
				hostAddr = 8'h40;
				hostWrData = 8'h99;
				@(negedge clk);
				accLoad = 1'b0;
				carryLoad = 1'b0;
				hostWrEn = 1'b0;
			end
		join
		peek(8'h40, 8'h22);
	endtask
	initial begin
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		cmp(acc, 8'h00);
		cmp({5'h00, flags}, 8'h00);
		t_sub_reg();
		t_sub_dir_ind();
		t_imm_swap();
		t_xch();
		t_refused();
		finish_test();
	end
	initial begin
		#20000;
		mismatches++;
		finish_test();
	end
endmodule
